// *** hdl/sfpc_top.sv ***
// serial flash link front end with status and write protection
`timescale 1ns/1ns

module sfpc_top #(
    parameter int ADDR_W = 20,
    parameter int PUW_CYCLES = sfpc_pkg::PUW_CYC_DEF,
    parameter int WRSR_CYCLES = sfpc_pkg::WRSR_CYC_DEF
) (
    // system clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    input wire logic dio_i,
    output logic dio_o,
    output logic dio_oe_o,
    output logic do_o,
    output logic do_oe_o,
    // array port on the link clock
    output logic [ADDR_W-1:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic [7:0] wr_byte_o,
    output logic wr_stb_o,
    // array port on the system clock
    output logic arr_req_o,
    output logic [7:0] arr_op_o,
    output logic [ADDR_W-1:0] arr_addr_o,
    input wire logic arr_done_i,
    output sfpc_pkg::sfpc_status_s status_o
);
    import sfpc_pkg::*;

    localparam int NBLK = 1 << (ADDR_W - BLK_SHIFT);

    // --------------------
    // link side: input
    // --------------------
    logic link_rst_n;
    logic first_ff;
    logic tog_ff;
    logic [6:0] sh_ff;
    sfpc_frame_s frm_ff;
    logic [15:0] cnt;
    logic [7:0] byte_in;
    logic [12:0] idx;
    logic byte_done;

    // select high clears the frame state; a pause with select high aborts
    assign link_rst_n = rstn_i & ~cs_n_i;
    assign cnt = first_ff ? 16'h0000 : frm_ff.nbits;
    assign byte_in = {sh_ff, dio_i};
    assign idx = cnt[15:3];
    assign byte_done = (cnt[2:0] == BIT_LAST);

    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            first_ff <= 1'b1;
        end else if (hold_n_i) begin
            first_ff <= 1'b0;
        end
    end

    // frame summary survives select high so the system side can read it
    // a clock edge while deselected (mode change between frames) must not count
    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frm_ff <= '0;
            sh_ff <= '0;
            tog_ff <= 1'b0;
        end else if (hold_n_i && !cs_n_i) begin
            sh_ff <= byte_in[6:0];
            frm_ff.nbits <= cnt + 16'h0001;
            if (first_ff) begin
                tog_ff <= ~tog_ff;
            end
            if (byte_done && idx == IDX_OP) begin
                frm_ff.op <= byte_in;
            end
            if (byte_done && idx != IDX_OP && idx <= IDX_ADDR) begin
                frm_ff.addr <= {frm_ff.addr[15:0], byte_in};
            end
            if (byte_done && idx == IDX_WDAT) begin
                frm_ff.wdat <= byte_in;
            end
        end
    end

    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            wr_stb_o <= 1'b0;
            wr_byte_o <= '0;
        end else begin
            wr_stb_o <= hold_n_i & byte_done & (idx >= IDX_DATA) & (frm_ff.op == OP_PP);
            if (hold_n_i && byte_done) begin
                wr_byte_o <= byte_in;
            end
        end
    end

    // --------------------
    // link side: output
    // --------------------
    logic [9:0] ls1_ff;
    logic [9:0] ls2_ff;
    sfpc_status_s l_sts;
    logic l_pd;
    logic l_armed;
    logic hold_hi_ff;
    logic hold_eff;
    logic sh_en;
    logic rdsr_go;
    logic rd_go;
    logic [15:0] n;
    logic [7:0] osh_ff;
    logic oen_ff;
    logic dual_ff;
    logic ld_ff;
    logic [ADDR_W-1:0] raddr_ff;
    sfpc_status_s sts;
    logic pd_ff;
    logic armed_ff;

    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ls1_ff <= '0;
            ls2_ff <= '0;
        end else begin
            ls1_ff <= {sts, pd_ff, armed_ff};
            ls2_ff <= ls1_ff;
        end
    end
    assign {l_sts, l_pd, l_armed} = ls2_ff;

    // with the clock high the pause keeps what the pin showed at the rise
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            hold_hi_ff <= 1'b0;
        end else begin
            hold_hi_ff <= ~hold_n_i;
        end
    end

    // clock low: pause follows the pin at once; clock high: wait for the fall
    assign hold_eff = sclk_i ? hold_hi_ff : ~hold_n_i;
    // of pauses, a fall is held off only by one already in force at the rise that began the high phase
    // first_ff guards a leading falling edge when the clock idles high
    assign sh_en = ~hold_hi_ff & ~first_ff;
    assign n = frm_ff.nbits;
    assign rdsr_go = (frm_ff.op == OP_RDSR) && n >= BITS_RDSR && n[2:0] == 3'h0
        && l_armed && !l_pd;
    assign rd_go = l_armed && !l_pd && !l_sts.busy && (
        (frm_ff.op == OP_READ && n >= BITS_ADDR && n[2:0] == 3'h0) ||
        (frm_ff.op == OP_FAST && n >= BITS_FAST && n[2:0] == 3'h0) ||
        (frm_ff.op == OP_DUAL && n >= BITS_FAST && n[1:0] == 2'h0));
    assign rd_addr_o = ld_ff ? raddr_ff : frm_ff.addr[ADDR_W-1:0];

    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            osh_ff <= '0;
            oen_ff <= 1'b0;
            dual_ff <= 1'b0;
            ld_ff <= 1'b0;
            raddr_ff <= '0;
        end else if (sh_en) begin
            if (rdsr_go || rd_go) begin
                osh_ff <= rdsr_go ? l_sts : rd_data_i;
                oen_ff <= 1'b1;
                dual_ff <= rd_go && frm_ff.op == OP_DUAL;
            end else if (dual_ff) begin
                osh_ff <= {osh_ff[5:0], 2'b00};
            end else begin
                osh_ff <= {osh_ff[6:0], 1'b0};
            end
            if (rd_go) begin
                ld_ff <= 1'b1;
                raddr_ff <= rd_addr_o + 1'b1;
            end
        end
    end

    assign do_o = osh_ff[7];
    assign dio_o = osh_ff[6];
    assign do_oe_o = oen_ff & ~hold_eff & ~cs_n_i;
    assign dio_oe_o = do_oe_o & dual_ff;

    // --------------------
    // system side: sync
    // --------------------
    logic [2:0] sy1_ff;
    logic [2:0] sy2_ff;
    logic cs_prev_ff;
    logic tog_seen_ff;
    logic [CNT_W-1:0] puw_cnt_ff;
    logic puw_done;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sy1_ff <= '0;
            sy2_ff <= '0;
        end else if (clk_en_i) begin
            sy1_ff <= {tog_ff, wp_n_i, cs_n_i};
            sy2_ff <= sy1_ff;
        end
    end

    // a frame counts only if select was seen high before it began
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_prev_ff <= 1'b0;
            tog_seen_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if (clk_en_i) begin
            cs_prev_ff <= sy2_ff[0];
            if (sy2_ff[0]) begin
                armed_ff <= 1'b1;
            end
            if (sy2_ff[0] && !cs_prev_ff) begin
                tog_seen_ff <= sy2_ff[2];
            end
        end
    end

    assign puw_done = (puw_cnt_ff == CNT_W'(PUW_CYCLES));

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            puw_cnt_ff <= '0;
        end else if (clk_en_i && !puw_done) begin
            puw_cnt_ff <= puw_cnt_ff + 1'b1;
        end
    end

    // --------------------
    // system side: decode
    // --------------------
    logic fe;
    logic go;
    logic wen;
    logic is_arr;
    logic len_ok;
    logic prot;
    logic acc_wren;
    logic acc_wrdi;
    logic acc_wrsr;
    logic acc_arr;
    logic acc_pd;
    logic acc_rpd;
    logic busy_ff;
    logic wel_ff;
    logic [2:0] bp_ff;
    logic tb_ff;
    logic lock_ff;
    int nprot;
    int blk;

    assign fe = clk_en_i & sy2_ff[0] & ~cs_prev_ff & armed_ff & (sy2_ff[2] != tog_seen_ff);
    assign go = fe & ~busy_ff & (frm_ff.nbits[2:0] == 3'h0);
    assign wen = go & ~pd_ff & puw_done & wel_ff;
    assign is_arr = frm_ff.op == OP_PP || frm_ff.op == OP_SE
        || frm_ff.op == OP_BE || frm_ff.op == OP_CE;
    assign len_ok = frm_ff.op == OP_CE || (frm_ff.op == OP_PP ?
        frm_ff.nbits >= BITS_FAST : frm_ff.nbits >= BITS_ADDR);
    assign acc_wren = go & ~pd_ff & puw_done & (frm_ff.op == OP_WREN);
    assign acc_wrdi = go & ~pd_ff & (frm_ff.op == OP_WRDI);
    assign acc_wrsr = wen & (frm_ff.op == OP_WRSR) & (frm_ff.nbits >= BITS_WRSR)
        & ~(lock_ff & ~sy2_ff[1]);
    assign acc_arr = wen & is_arr & len_ok & ~prot;
    assign acc_pd = go & ~pd_ff & (frm_ff.op == OP_PD);
    assign acc_rpd = go & pd_ff & (frm_ff.op == OP_RPD);

    always_comb begin
        nprot = (bp_ff == BP_NONE) ? 0 : (1 << (int'(bp_ff) - 1));
        blk = int'(frm_ff.addr[ADDR_W-1:BLK_SHIFT]);
        if (frm_ff.op == OP_CE) begin
            prot = (bp_ff != BP_NONE);
        end else if (nprot >= NBLK) begin
            prot = 1'b1;
        end else if (tb_ff) begin
            prot = (blk < nprot);
        end else begin
            prot = (blk >= NBLK - nprot);
        end
    end

    // --------------------
    // system side: state
    // --------------------
    sfpc_busy_e state_ff;
    logic [CNT_W-1:0] wr_cnt_ff;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= BSY_IDLE;
            busy_ff <= 1'b0;
            wr_cnt_ff <= '0;
        end else if (clk_en_i) begin
            unique case (state_ff)
                BSY_IDLE: begin
                    wr_cnt_ff <= '0;
                    if (acc_wrsr) begin
                        state_ff <= BSY_WRSR;
                        busy_ff <= 1'b1;
                    end else if (acc_arr) begin
                        state_ff <= BSY_ARRAY;
                        busy_ff <= 1'b1;
                    end
                end
                BSY_WRSR: begin
                    wr_cnt_ff <= wr_cnt_ff + 1'b1;
                    if (wr_cnt_ff == CNT_W'(WRSR_CYCLES - 1)) begin
                        state_ff <= BSY_IDLE;
                        busy_ff <= 1'b0;
                    end
                end
                BSY_ARRAY: begin
                    if (arr_done_i) begin
                        state_ff <= BSY_IDLE;
                        busy_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wel_ff <= 1'b0;
            pd_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (acc_wren) begin
                wel_ff <= 1'b1;
            end else if (acc_wrdi || acc_wrsr || acc_arr) begin
                wel_ff <= 1'b0;
            end
            if (acc_pd) begin
                pd_ff <= 1'b1;
            end else if (acc_rpd) begin
                pd_ff <= 1'b0;
            end
        end
    end

    // nonvolatile storage lives outside; reset loads the shipped defaults
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bp_ff <= BP_NONE;
            tb_ff <= TB_DEF;
            lock_ff <= LOCK_DEF;
        end else if (clk_en_i && acc_wrsr) begin
            lock_ff <= frm_ff.wdat[7];
            tb_ff <= frm_ff.wdat[5];
            bp_ff <= frm_ff.wdat[4:2];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            arr_req_o <= 1'b0;
            arr_op_o <= '0;
            arr_addr_o <= '0;
        end else if (clk_en_i) begin
            arr_req_o <= acc_arr;
            if (acc_arr) begin
                arr_op_o <= frm_ff.op;
                arr_addr_o <= frm_ff.addr[ADDR_W-1:0];
            end
        end
    end

    assign sts = {lock_ff, RSVD_VAL, tb_ff, bp_ff, wel_ff, busy_ff};
    assign status_o = sts;

    // --------------------
    // assertions
    // --------------------
    sequence s_wrsr_hold;
        ##1 busy_ff ##1 busy_ff;
    endsequence

    property p_wel_set;
        @(posedge sys_clk_i) disable iff (!rstn_i) acc_wren |=> wel_ff;
    endproperty
    a_wel_set: assert property (p_wel_set)
        else $error("write enable latch not set");

    property p_wel_clr;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (acc_wrdi || acc_wrsr || acc_arr) |=> !wel_ff;
    endproperty
    a_wel_clr: assert property (p_wel_clr)
        else $error("write enable latch not cleared");

    property p_puw_lock;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (!puw_done && !wel_ff) |=> !wel_ff;
    endproperty
    a_puw_lock: assert property (p_puw_lock)
        else $error("write enabled before power-up delay");

    property p_busy_only_rdsr;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (busy_ff && fe) |=> $stable(wel_ff) && $stable(pd_ff) && !arr_req_o;
    endproperty
    a_busy_only_rdsr: assert property (p_busy_only_rdsr)
        else $error("instruction taken while busy");

    property p_wrsr_busy;
        @(posedge sys_clk_i) disable iff (!rstn_i) acc_wrsr |-> s_wrsr_hold;
    endproperty
    a_wrsr_busy: assert property (p_wrsr_busy)
        else $error("busy not held after status write");

    property p_arr_done;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (clk_en_i && state_ff == BSY_ARRAY && arr_done_i) |=> !busy_ff;
    endproperty
    a_arr_done: assert property (p_arr_done)
        else $error("busy not cleared on completion");

    property p_lock;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (fe && frm_ff.op == OP_WRSR && lock_ff && !sy2_ff[1]) |=>
            $stable(bp_ff) && $stable(tb_ff);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked status written");

    property p_pd_ignore;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (pd_ff && fe && frm_ff.op != OP_RPD) |=> pd_ff && $stable(sts);
    endproperty
    a_pd_ignore: assert property (p_pd_ignore)
        else $error("instruction taken in power-down");

    property p_prot;
        @(posedge sys_clk_i) disable iff (!rstn_i) (fe && prot) |=> !arr_req_o;
    endproperty
    a_prot: assert property (p_prot)
        else $error("protected region written");

    property p_desel;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        cs_n_i |-> !do_oe_o && !dio_oe_o && !oen_ff && !dual_ff;
    endproperty
    a_desel: assert property (p_desel)
        else $error("output driven while deselected");

    property p_dual_only;
        @(negedge sclk_i) disable iff (!link_rst_n)
        (sh_en && rd_go && frm_ff.op != OP_DUAL) |=> !dio_oe_o;
    endproperty
    a_dual_only: assert property (p_dual_only)
        else $error("io pin driven outside dual read");

    property p_rsvd;
        @(negedge sclk_i) disable iff (!link_rst_n) (sh_en && rdsr_go) |=> !osh_ff[6];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved status bit not zero");

endmodule : sfpc_top

// *** hdl/sfpc_pkg.sv ***
// package: constants and types of the serial flash front end
package sfpc_pkg;

    // --------------------
    // instruction codes
    // --------------------
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_DUAL = 8'h3b;
    localparam logic [7:0] OP_RPD = 8'hab;
    localparam logic [7:0] OP_PD = 8'hb9;
    localparam logic [7:0] OP_CE = 8'hc7;
    localparam logic [7:0] OP_BE = 8'hd8;

    // --------------------
    // timing
    // --------------------
    localparam int SYS_CLK_MHZ = 50;
    localparam int PUW_TIME_US = 10;
    localparam int WRSR_TIME_US = 10;
    localparam int PUW_CYC_DEF = PUW_TIME_US * SYS_CLK_MHZ;
    localparam int WRSR_CYC_DEF = WRSR_TIME_US * SYS_CLK_MHZ;
    localparam int CNT_W = 24;

    // --------------------
    // frame positions
    // --------------------
    localparam logic [15:0] BITS_RDSR = 16'h0008;
    localparam logic [15:0] BITS_WRSR = 16'h0010;
    localparam logic [15:0] BITS_ADDR = 16'h0020;
    localparam logic [15:0] BITS_FAST = 16'h0028;
    localparam logic [12:0] IDX_OP = 13'h0000;
    localparam logic [12:0] IDX_WDAT = 13'h0001;
    localparam logic [12:0] IDX_ADDR = 13'h0003;
    localparam logic [12:0] IDX_DATA = 13'h0004;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int BLK_SHIFT = 16;

    // --------------------
    // status defaults
    // --------------------
    localparam logic RSVD_VAL = 1'b0;
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic TB_DEF = 1'b0;
    localparam logic LOCK_DEF = 1'b0;

    typedef struct packed {
        logic lock;
        logic rsvd;
        logic tb;
        logic [2:0] bp;
        logic write_enable_latch;
        logic busy;
    } sfpc_status_s;

    typedef struct packed {
        logic [7:0] op;
        logic [23:0] addr;
        logic [7:0] wdat;
        logic [15:0] nbits;
    } sfpc_frame_s;

    typedef enum {BSY_IDLE, BSY_WRSR, BSY_ARRAY} sfpc_busy_e;

endpackage : sfpc_pkg

// *** verif/sfpc_master.sv ***
// partner: link master that drives frames and pauses and samples the data lines
`timescale 1ns/1ns
module sfpc_master (
    // link pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic hold_n_o,
    output logic dio_o,
    input wire logic do_i,
    input wire logic do_oe_i,
    input wire logic dio_i,
    // pause observation
    output logic hold_oe_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        hold_n_o = 1'b1;
        dio_o = 1'b0;
        hold_oe_o = 1'b0;
    end

    // clock runs only inside frames; its idle level picks mode 0 or 3
    task automatic xfer(input logic [63:0] tx, input int n, input bit m3, input int hat,
                        output logic [15:0] rx, output logic [15:0] rx2);
        rx = 16'h0000;
        rx2 = 16'h0000;
        sclk_o = m3;
        #63;
        cs_n_o = 1'b0;
        #63;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b0;
            if (i == hat) begin
                #10 hold_n_o = 1'b0;
                // junk clocks and data while paused must not shift anything
                repeat (4) begin
                    #20 sclk_o = ~sclk_o;
                    dio_o = ~dio_o;
                end
                hold_oe_o = do_oe_i;
                hold_n_o = 1'b1;
                #20;
            end
            dio_o = tx[63-i];
            #62;
            // sample what stood through the low phase, just ahead of the rise
            // an undriven output shows the inverse of the last bit, never a stale copy
            rx = {rx[14:0], do_oe_i ? do_i : ~rx[0]};
            rx2 = {rx2[14:0], dio_i};
            sclk_o = 1'b1;
            #63;
        end
        if (!m3) sclk_o = 1'b0;
        #63 cs_n_o = 1'b1;
        #300;
    endtask : xfer
endmodule : sfpc_master

// *** verif/test_serial_flash_spi_protect_ctrl.sv ***
// testbench: link frames checked against a behavioural status and protection model
`timescale 1ns/1ns
module test_serial_flash_spi_protect_ctrl;
    import sfpc_pkg::*;
    localparam int PUW_N = 100;
    localparam int WRSR_N = 400;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wp_n_i = 1'b1;
    logic arr_done_i = 1'b0;
    logic sclk, cs_n, hold_n, m_dio, dio_o, dio_oe_o, do_o, do_oe_o, hold_oe, arr_req_o;
    logic [19:0] rd_addr_o;
    logic [19:0] arr_addr_o;
    logic [7:0] arr_op_o;
    logic [15:0] rx;
    logic [15:0] rx2;
    logic [23:0] a;
    sfpc_status_s status_o;
    int error_cnt = 0;
    int checks = 0;
    int req_cnt = 0;
    int write_enable_latch = 0, busy = 0, bp = 0, tb = 0, lock = 0, puw = 0, pd = 0, n = 0, prot = 0;
    wire logic dio_w = dio_oe_o ? dio_o : m_dio;
    wire logic [7:0] rd_data = rd_addr_o[7:0] ^ 8'h5a;

    sfpc_top #(.PUW_CYCLES(PUW_N), .WRSR_CYCLES(WRSR_N)) i_sfpc_top (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
        .hold_n_i(hold_n), .wp_n_i(wp_n_i), .dio_i(dio_w), .dio_o(dio_o), .dio_oe_o(dio_oe_o),
        .do_o(do_o), .do_oe_o(do_oe_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data),
        .wr_byte_o(), .wr_stb_o(), .arr_req_o(arr_req_o), .arr_op_o(arr_op_o),
        .arr_addr_o(arr_addr_o), .arr_done_i(arr_done_i), .status_o(status_o));
    sfpc_master i_sfpc_master (.sclk_o(sclk), .cs_n_o(cs_n), .hold_n_o(hold_n), .dio_o(m_dio),
        .do_i(do_o), .do_oe_i(do_oe_o), .dio_i(dio_w), .hold_oe_o(hold_oe));

    initial forever #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (arr_req_o === 1'b1) req_cnt <= req_cnt + 1;

    // ----------------
    // model and tasks
    // ----------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic summarize();
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    function automatic logic [7:0] sr();
        return {lock[0], 1'b0, tb[0], bp[2:0], write_enable_latch[0], busy[0]};
    endfunction : sr
    function automatic logic [7:0] dual(input logic [15:0] w, input int o);
        logic [7:0] r;
        for (int j = 0; j < 8; j++) r[7-j] = w[15-2*j-o];
        return r;
    endfunction : dual
    task automatic frame(input logic [63:0] tx, input int nb, input int hat = -1);
        i_sfpc_master.xfer(tx, nb, 1'($urandom_range(1)), hat, rx, rx2);
    endtask : frame
    task automatic rdsr(input int hat = -1);
        frame({OP_RDSR, 56'h0}, 16, hat);
        check("status read", rx[7:0], sr());
        check("status masked", rx[7:0] & 8'hbf, sr() & 8'hbf);
    endtask : rdsr
    task automatic wren();
        frame({OP_WREN, 56'h0}, 8);
        if (puw && !busy && !pd) write_enable_latch = 1;
    endtask : wren
    task automatic wrsr(input logic [7:0] d);
        frame({OP_WRSR, d, 48'h0}, 16);
        if (write_enable_latch && !busy && !(lock && !wp_n_i)) begin
            lock = d[7];
            tb = d[5];
            bp = d[4:2];
            write_enable_latch = 0;
            busy = 1;
        end
    endtask : wrsr
    task automatic settle();
        repeat (WRSR_N + 20) @(posedge sys_clk_i);
        busy = 0;
        check("status port", status_o, sr());
    endtask : settle

    // ----------------
    // sequence
    // ----------------
    initial begin
        void'($urandom(32'he672));
        repeat (20) @(posedge sys_clk_i);
        check("status in reset", status_o, 8'h00);
        check("output in reset", do_oe_o, 1'b0);
        rstn_i <= 1'b1;
        wren();
        rdsr();
        repeat (PUW_N) @(posedge sys_clk_i);
        puw = 1;
        wrsr(8'h1c);
        rdsr();
        wren();
        rdsr(10);
        check("paused output", hold_oe, 1'b0);
        frame({OP_WRDI, 56'h0}, 8);
        write_enable_latch = 0;
        rdsr();
        wren();
        wrsr(8'($urandom) & 8'h7f);
        rdsr();
        wren();
        rdsr();
        settle();
        wren();
        wrsr(8'h80);
        settle();
        @(posedge sys_clk_i) wp_n_i <= 1'b0;
        wren();
        wrsr(8'h04);
        rdsr();
        @(posedge sys_clk_i) wp_n_i <= 1'b1;
        wrsr(8'h00);
        settle();
        for (int t = 0; t < 2; t++) begin
            for (int k = 0; k < 2; k++) begin
                wren();
                wrsr({2'b00, t[0], 3'b001, 2'b00});
                settle();
                a = k ? 24'h0f1234 : 24'h001234;
                prot = (t == 0) == (k == 1);
                wren();
                n = req_cnt;
                frame({OP_SE, a, 32'h0}, 32);
                check("erase request", req_cnt - n, prot ? 0 : 1);
                if (!prot) begin
                    check("erase addr", arr_addr_o, a[19:0]);
                    check("erase op", arr_op_o, OP_SE);
                    write_enable_latch = 0;
                    busy = 1;
                    rdsr();
                    @(posedge sys_clk_i) arr_done_i <= 1'b1;
                    @(posedge sys_clk_i) arr_done_i <= 1'b0;
                    busy = 0;
                end
                rdsr();
            end
        end
        wren();
        n = req_cnt;
        frame({OP_SE, 24'h081234, 32'h0}, 33);
        check("unaligned erase", req_cnt - n, 0);
        rdsr();
        frame({OP_READ, 24'h000010, 32'h0}, 48);
        check("read data", rx, {8'h10 ^ 8'h5a, 8'h11 ^ 8'h5a});
        frame({OP_DUAL, 24'h000020, 32'h0}, 48);
        check("dual do", rx[7:0], dual({8'h20 ^ 8'h5a, 8'h21 ^ 8'h5a}, 0));
        check("dual dio", rx2[7:0], dual({8'h20 ^ 8'h5a, 8'h21 ^ 8'h5a}, 1));
        frame({OP_WRDI, 56'h0}, 8);
        write_enable_latch = 0;
        frame({OP_PD, 56'h0}, 8);
        pd = 1;
        wren();
        frame({OP_RPD, 56'h0}, 8);
        pd = 0;
        rdsr();
        summarize();
    end

    // a hang counts as a mismatch
    initial begin
        #1_000_000;
        error_cnt++;
        summarize();
    end
endmodule : test_serial_flash_spi_protect_ctrl
